// ---- pta_target.v ----
// pci target access control: decode, interlock, termination
`timescale 1ns/1ps
`include "pta_consts.vh"
module pta_target (
   input wire i_clk, // pci clock, 25 MHz
   input wire i_rst_n, // synchronous reset, active low
   input wire [31:0] i_ad, // address/data in
   input wire [3:0] i_cbe_n, // command / byte enables, active low
   input wire i_frame_n, // frame, active low
   input wire i_irdy_n, // initiator ready, active low
   input wire i_idsel, // configuration select
   output reg [31:0] o_ad, // read data out
   output reg o_ad_oe_n, // ad output enable, low drives
   output reg o_trdy_n, // target ready, active low
   output reg o_stop_n, // stop, active low
   output reg o_devsel_n, // devsel, active low
   output reg o_ctl_oe_n, // trdy/stop/devsel enable, low drives
   input wire [31:0] i_bar0, // device_base_addr_0
   input wire [31:0] i_bar1, // device_base_addr_1
   input wire [31:0] i_rom_bar, // expansion_rom_base_addr
   input wire i_rom_en, // expansion rom decode enable
   input wire i_busy, // busy bit of command_status_reg
   input wire i_dma_active, // dma in progress
   output reg o_reg_rd, // core/base 1/bypass register read strobe
   output reg o_reg_wr, // register write strobe (base 1, cfg, io)
   output reg o_cfg_sel, // register access targets config space
   output reg [31:0] o_reg_addr, // register address
   output reg [31:0] o_reg_wdata, // register write data
   input wire [31:0] i_reg_rdata, // register read data, same cycle
   output reg o_path_req, // frame_buffer_device_access_path request
   output reg [31:0] o_path_addr, // access path address
   output reg [3:0] o_path_be_n, // access path byte enables
   input wire i_path_ack, // access path data valid pulse
   input wire [31:0] i_path_rdata, // access path read data
   input wire i_cmdq_full, // command queue full
   output reg o_cmdq_wr, // command queue push
   output reg [35:0] o_cmdq_data, // queue entry {be_n, addr or data}
   output reg o_cmdq_is_addr, // entry carries an address
   output reg o_snoop // dac snoop pulse after transfer
);
   // ------------------------------------------------------------
   // states (one hot)
   // ------------------------------------------------------------
   localparam [7:0] ST_IDLE = 8'h01;
   localparam [7:0] ST_WAIT = 8'h02; // busy or queue wait
   localparam [7:0] ST_FETCH = 8'h04; // access path or register read pending
   localparam [7:0] ST_DATA = 8'h08; // read: trdy asserted; write: waiting irdy
   localparam [7:0] ST_TERM = 8'h10; // stop, trdy high
   localparam [7:0] ST_WRQ = 8'h20; // base 0 write burst
   localparam [7:0] ST_DROP = 8'h40; // release bus
   localparam [7:0] ST_IGN = 8'h80; // not ours, wait frame end

   reg [7:0] st_reg;
   reg [2:0] sp_reg;
   reg rd_reg;
   reg io_reg;
   reg [31:0] addr_reg;
   reg pend_reg; // write data latched awaiting snoop
   reg count_en;
   reg clr_wait;
   wire expired;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function in_win;
      input [31:0] a;
      input [31:0] base;
      input [31:0] mask;
      begin
         in_win = ((a & mask) == (base & mask));
      end
   endfunction

   // command folding: invalidate and line/multiple reads map to plain
   function [3:0] fold_cmd;
      input [3:0] c;
      begin
         case (c)
            `PTA_CMD_MEM_WR_INV: fold_cmd = `PTA_CMD_MEM_WR;
            `PTA_CMD_MEM_RD_LINE, `PTA_CMD_MEM_RD_MULT:
               fold_cmd = `PTA_CMD_MEM_RD;
            default: fold_cmd = c;
         endcase
      end
   endfunction

   // legal byte enables for a vga/dac io port: must address own byte
   function io_be_ok;
      input [1:0] a;
      input [3:0] be_n;
      begin
         io_be_ok = (be_n != `PTA_BE_NONE) && ((be_n >> a) & 4'h1) == 4'h0
            && ((~be_n & ((4'h1 << a) - 4'h1)) == 4'h0);
      end
   endfunction

   wire [3:0] cmd = fold_cmd(i_cbe_n);
   wire start = (st_reg == ST_IDLE) && !i_frame_n;
   wire is_mem = (cmd == `PTA_CMD_MEM_RD) || (cmd == `PTA_CMD_MEM_WR);
   wire is_cfg = i_idsel && (i_ad[1:0] == 2'b00) &&
      ((cmd == `PTA_CMD_CFG_RD) || (cmd == `PTA_CMD_CFG_WR));
   wire is_io = (cmd == `PTA_CMD_IO_RD) || (cmd == `PTA_CMD_IO_WR);
   wire hit0 = is_mem && in_win(i_ad, i_bar0, `PTA_BAR0_MASK);
   wire hit1 = is_mem && in_win(i_ad, i_bar1, `PTA_BAR1_MASK);
   wire hitr = is_mem && i_rom_en && in_win(i_ad, i_rom_bar, `PTA_ROM_MASK);
   wire hit_io = is_io && i_ad[15:0] >= `PTA_VGA_IO_LO && i_ad[15:0] <= `PTA_VGA_IO_HI;
   wire cmd_rd = (cmd == `PTA_CMD_MEM_RD) || (cmd == `PTA_CMD_CFG_RD) ||
      (cmd == `PTA_CMD_IO_RD);
   wire burst = !i_frame_n;
   wire irdy = !i_irdy_n;

   // space classification at the address phase
   reg [2:0] sp_dec;
   always @* begin
      sp_dec = `PTA_SP_NONE;
      if (is_cfg || hit_io) begin
         sp_dec = `PTA_SP_BYPASS;
      end else if (hit0) begin
         if (i_ad[`PTA_CORE_FB_BIT])
            sp_dec = `PTA_SP_FB;
         else if (i_ad[`PTA_CORE_RES_BIT])
            sp_dec = `PTA_SP_RESERVED;
         else
            sp_dec = `PTA_SP_CORE_REG;
      end else if (hit1) begin
         if (i_ad[`PTA_B1_ALTROM_BIT])
            sp_dec = `PTA_SP_ALT_ROM;
         else if (i_ad[`PTA_B1_BYPASS_BIT])
            sp_dec = `PTA_SP_BYPASS;
         else
            sp_dec = `PTA_SP_BAR1;
      end else if (hitr) begin
         // rom window writes behave as reserved writes
         sp_dec = cmd_rd ? `PTA_SP_ROM : `PTA_SP_RESERVED;
      end
   end

   wire interlock = (sp_reg == `PTA_SP_CORE_REG) || (sp_reg == `PTA_SP_FB) ||
      (sp_reg == `PTA_SP_ALT_ROM) || (sp_reg == `PTA_SP_ROM);
   // dma retries only reads of core, frame buffer and rom spaces; trades fairness for ordering
   wire busy_now = i_busy || (i_dma_active && sp_reg != `PTA_SP_BYPASS);

   pta_wait_cnt i_pta_wait_cnt (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_clear(clr_wait),
      .i_count(count_en),
      .o_expired(expired)
   );

   // ------------------------------------------------------------
   // wait counter control
   // ------------------------------------------------------------
   always @* begin
      clr_wait = (st_reg != ST_WAIT) && (st_reg != ST_WRQ);
      count_en = (st_reg == ST_WAIT) ||
         ((st_reg == ST_WRQ) && i_cmdq_full);
      if (st_reg == ST_WRQ && !i_cmdq_full)
         clr_wait = 1'b1;
   end

   // ------------------------------------------------------------
   // main target state machine
   // ------------------------------------------------------------
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_reg <= ST_IDLE;
         sp_reg <= `PTA_SP_NONE;
         rd_reg <= 1'b0;
         io_reg <= 1'b0;
         addr_reg <= 32'h00000000;
         pend_reg <= 1'b0;
         o_ad <= 32'h00000000;
         o_ad_oe_n <= 1'b1;
         o_trdy_n <= 1'b1;
         o_stop_n <= 1'b1;
         o_devsel_n <= 1'b1;
         o_ctl_oe_n <= 1'b1;
         o_reg_rd <= 1'b0;
         o_reg_wr <= 1'b0;
         o_cfg_sel <= 1'b0;
         o_reg_addr <= 32'h00000000;
         o_reg_wdata <= 32'h00000000;
         o_path_req <= 1'b0;
         o_path_addr <= 32'h00000000;
         o_path_be_n <= 4'h0;
         o_cmdq_wr <= 1'b0;
         o_cmdq_data <= 36'h000000000;
         o_cmdq_is_addr <= 1'b0;
         o_snoop <= 1'b0;
      end else begin
         o_reg_rd <= 1'b0;
         o_reg_wr <= 1'b0;
         o_path_req <= 1'b0;
         o_cmdq_wr <= 1'b0;
         o_snoop <= 1'b0;
         case (st_reg)
            ST_IDLE: begin
               o_ctl_oe_n <= 1'b1;
               if (start) begin
                  addr_reg <= i_ad;
                  rd_reg <= cmd_rd;
                  io_reg <= hit_io;
                  o_cfg_sel <= is_cfg;
                  sp_reg <= sp_dec;
                  if (sp_dec == `PTA_SP_NONE) begin
                     st_reg <= ST_IGN;
                  end else begin
                     o_devsel_n <= 1'b0;
                     o_ctl_oe_n <= 1'b0;
                     if (cmd_rd) begin
                        o_ad_oe_n <= 1'b0;
                        st_reg <= ST_WAIT;
                     end else if (sp_dec == `PTA_SP_FB || sp_dec == `PTA_SP_CORE_REG)
                     begin
                        // base 0 writes queue the address first
                        o_cmdq_data <= {4'h0, i_ad};
                        o_cmdq_is_addr <= 1'b1;
                        st_reg <= i_cmdq_full ? ST_WAIT : ST_WRQ;
                        o_cmdq_wr <= !i_cmdq_full;
                     end else begin
                        st_reg <= ST_DATA; // writes wait irdy in ST_DATA
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (rd_reg && io_reg && !io_be_ok(addr_reg[1:0], i_cbe_n)) begin
                  o_devsel_n <= 1'b1; // io read with bad byte enables
                  o_stop_n <= 1'b0;
                  st_reg <= ST_TERM;
               end else if (rd_reg && (!interlock || !busy_now)) begin
                  if (sp_reg == `PTA_SP_FB || sp_reg == `PTA_SP_ROM ||
                      sp_reg == `PTA_SP_ALT_ROM) begin
                     o_path_req <= 1'b1;
                     o_path_be_n <= (sp_reg == `PTA_SP_FB) ? i_cbe_n : 4'h0;
                     o_path_addr <= (sp_reg == `PTA_SP_ALT_ROM) ?
                        {addr_reg[29:2], 4'h0} : addr_reg;
                     st_reg <= ST_FETCH;
                  end else begin
                     o_reg_rd <= (sp_reg != `PTA_SP_RESERVED);
                     o_reg_addr <= addr_reg;
                     st_reg <= ST_FETCH;
                  end
               end else if (!rd_reg && !i_cmdq_full) begin
                  o_cmdq_data <= {4'h0, addr_reg};
                  o_cmdq_is_addr <= 1'b1;
                  o_cmdq_wr <= 1'b1;
                  st_reg <= ST_WRQ;
               end else if (expired) begin
                  // retry: stop without trdy, first phase only
                  o_stop_n <= 1'b0;
                  st_reg <= ST_TERM;
               end
            end
            ST_FETCH: begin
               if (o_reg_rd || i_path_ack || sp_reg == `PTA_SP_RESERVED) begin
                  if (sp_reg == `PTA_SP_RESERVED || (o_cfg_sel && o_reg_addr[7:2] > 6'h0F))
                     o_ad <= 32'h00000000;
                  else
                     o_ad <= o_reg_rd ? i_reg_rdata : i_path_rdata;
                  o_trdy_n <= 1'b0;
                  st_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (rd_reg) begin
                  // trdy held until irdy, then frame tested
                  if (irdy) begin
                     o_trdy_n <= 1'b1;
                     if (burst) begin
                        o_stop_n <= 1'b0;
                        st_reg <= ST_TERM;
                     end else begin
                        st_reg <= ST_DROP;
                     end
                  end
               end else if (irdy) begin
                  // write: latch then complete; null phase is a no-op
                  if (i_cbe_n != `PTA_BE_NONE && sp_reg != `PTA_SP_RESERVED &&
                      !(o_cfg_sel && addr_reg[7:2] > 6'h0F)) begin
                     o_reg_wr <= !io_reg || io_be_ok(addr_reg[1:0], i_cbe_n);
                     o_reg_addr <= addr_reg;
                     o_reg_wdata <= i_ad; // all 32 bits
                  end
                  if (io_reg && i_cbe_n != `PTA_BE_NONE && !io_be_ok(addr_reg[1:0], i_cbe_n))
                  begin
                     // bad io byte enables abort; base spaces never reach here
                     o_devsel_n <= 1'b1;
                     o_stop_n <= 1'b0;
                     st_reg <= ST_TERM;
                  end else begin
                     o_trdy_n <= 1'b0;
                     pend_reg <= io_reg;
                     o_stop_n <= !burst;
                     st_reg <= burst ? ST_TERM : ST_DROP;
                  end
               end
            end
            ST_WRQ: begin
               if (irdy && !o_trdy_n) begin
                  // queued phase accepted this edge
                  o_trdy_n <= 1'b1;
               end else if (irdy && !i_cmdq_full) begin
                  o_cmdq_data <= {i_cbe_n, i_ad};
                  o_cmdq_is_addr <= 1'b0;
                  o_cmdq_wr <= 1'b1;
                  o_trdy_n <= 1'b0;
                  if (!burst)
                     st_reg <= ST_DROP;
               end else if (expired) begin
                  o_stop_n <= 1'b0;
                  st_reg <= ST_TERM;
               end else if (i_frame_n && !irdy) begin
                  st_reg <= ST_DROP;
               end
            end
            ST_TERM: begin
               o_trdy_n <= 1'b1;
               // hold stop until master drops frame, rely on repeat
               if (i_frame_n) begin
                  st_reg <= ST_DROP;
               end
            end
            ST_DROP: begin
               // snoop follows the completed transfer
               o_snoop <= pend_reg;
               pend_reg <= 1'b0;
               o_trdy_n <= 1'b1;
               o_stop_n <= 1'b1;
               o_devsel_n <= 1'b1;
               o_ad_oe_n <= 1'b1;
               st_reg <= ST_IDLE;
            end
            ST_IGN: begin
               if (i_frame_n && i_irdy_n)
                  st_reg <= ST_IDLE;
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // pta_target

// ---- pta_consts.vh ----
// constants for the pci target access control block
`ifndef PTA_CONSTS_VH
`define PTA_CONSTS_VH
// pci bus commands
`define PTA_CMD_IO_RD 4'h2
`define PTA_CMD_IO_WR 4'h3
`define PTA_CMD_MEM_RD 4'h6
`define PTA_CMD_MEM_WR 4'h7
`define PTA_CMD_CFG_RD 4'hA
`define PTA_CMD_CFG_WR 4'hB
`define PTA_CMD_MEM_RD_MULT 4'hC
`define PTA_CMD_MEM_RD_LINE 4'hE
`define PTA_CMD_MEM_WR_INV 4'hF
// byte enable value meaning no byte enabled
`define PTA_BE_NONE 4'hF
// wait limit in pci clocks for idle or queue space
`define PTA_WAIT_LIMIT 4'h8
// rom address shift for alternate rom space
`define PTA_ROM_SHIFT 2
// address space codes
`define PTA_SP_NONE 3'h0
`define PTA_SP_CORE_REG 3'h1
`define PTA_SP_FB 3'h2
`define PTA_SP_BYPASS 3'h3
`define PTA_SP_BAR1 3'h4
`define PTA_SP_ROM 3'h5
`define PTA_SP_ALT_ROM 3'h6
`define PTA_SP_RESERVED 3'h7
// window sizes as address masks
`define PTA_BAR0_MASK 32'hFE000000
`define PTA_BAR1_MASK 32'hFFFC0000
`define PTA_ROM_MASK 32'hFFFC0000
// core space layout inside base address 0 (one copy in 4MB)
`define PTA_CORE_FB_BIT 21
`define PTA_CORE_RES_BIT 20
// base address 1 layout
`define PTA_B1_ALTROM_BIT 17
`define PTA_B1_BYPASS_BIT 16
// vga io ports owned, dac io ports owned
`define PTA_VGA_IO_LO 16'h03B0
`define PTA_VGA_IO_HI 16'h03DF
`define PTA_DAC_IO_BASE 16'h03C4
// command queue depth
`define PTA_CMDQ_DEPTH 64
`endif

// ---- pta_wait_cnt.v ----
// wait counter for retry and disconnect decisions
`timescale 1ns/1ps
`include "pta_consts.vh"
module pta_wait_cnt (
   input wire i_clk, // pci clock
   input wire i_rst_n, // synchronous reset, active low
   input wire i_clear, // restart the count at zero
   input wire i_count, // one wait clock elapsed
   output wire o_expired // limit reached
);
   reg [3:0] cnt_reg;
   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   // clear wins so every new wait starts fresh
   always @(posedge i_clk) begin
      if (!i_rst_n || i_clear) begin
         cnt_reg <= 4'h0;
      end else if (i_count && cnt_reg != `PTA_WAIT_LIMIT) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   assign o_expired = (cnt_reg == `PTA_WAIT_LIMIT);
endmodule // pta_wait_cnt

// ---- pta_target_checker.sv ----
// port-level assertions for the pci target access control block
`timescale 1ns/1ps
`include "pta_consts.vh"
module pta_target_checker (
   input wire i_clk, // pci clock
   input wire i_rst_n, // sync reset, active low
   input wire [31:0] i_ad, // ad bus as seen
   input wire [3:0] i_cbe_n, // command / byte enables
   input wire i_frame_n, // frame
   input wire i_irdy_n, // initiator ready
   input wire [31:0] i_bar0, // base 0 window
   input wire i_cmdq_full, // queue full
   input wire o_trdy_n, // target ready
   input wire o_stop_n, // stop
   input wire o_devsel_n, // devsel
   input wire o_ctl_oe_n, // control enable
   input wire o_ad_oe_n, // ad enable
   input wire o_cmdq_wr, // queue push
   input wire o_path_req // fetch request
);
// ----------------------------------------
// transaction tracking
// ----------------------------------------
reg frame_q_reg;
reg [3:0] cmd_reg;
reg data_reg;
wire addr_ph = !i_frame_n && frame_q_reg && o_devsel_n;
wire rd_cmd = !cmd_reg[0];
wire is_cfg = cmd_reg[3:1] == 3'b101;
wire is_mem = !is_cfg && (cmd_reg[3:1] != 3'b001);
// latch the command at the address phase; note completed data phases
always @(posedge i_clk) begin
   if (!i_rst_n) begin
      frame_q_reg <= 1'b1;
      cmd_reg <= 4'h0;
      data_reg <= 1'b0;
   end else begin
      frame_q_reg <= i_frame_n;
      if (addr_ph) begin
         cmd_reg <= i_cbe_n;
      end
      data_reg <= addr_ph ? 1'b0 : (data_reg || (!o_trdy_n && !i_irdy_n));
   end
end
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
// ----------------------------------------
// properties
// ----------------------------------------
property p_trdy_hold; !o_trdy_n && i_irdy_n && !o_ctl_oe_n |=> !o_trdy_n; endproperty
a_trdy_hold: assert property (p_trdy_hold) else $error("trdy dropped before irdy");
property p_burst_disc; !o_trdy_n && !i_irdy_n && !i_frame_n && rd_cmd |=> o_trdy_n && !o_stop_n;
endproperty
a_burst_disc: assert property (p_burst_disc) else $error("burst read not disconnected");
property p_one_fetch; o_path_req |=> !o_path_req [*8]; endproperty
a_one_fetch: assert property (p_one_fetch) else $error("second fetch request");
property p_release; !o_stop_n && i_frame_n && !i_irdy_n |=> ##[0:1] o_stop_n; endproperty
a_release: assert property (p_release) else $error("stop held after last phase");
property p_no_mem_abort; !o_ctl_oe_n && o_devsel_n && !o_stop_n |-> !is_mem; endproperty
a_no_mem_abort: assert property (p_no_mem_abort) else $error("target abort on memory");
property p_no_cfg_retry; !o_stop_n && !o_devsel_n && is_cfg |-> data_reg || !o_trdy_n; endproperty
a_no_cfg_retry: assert property (p_no_cfg_retry) else $error("retry on config access");
property p_push_free; o_cmdq_wr |-> !$past(i_cmdq_full); endproperty
a_push_free: assert property (p_push_free) else $error("push into full queue");
property p_claim;
   addr_ph && ((i_ad & `PTA_BAR0_MASK) == i_bar0) && (i_cbe_n == `PTA_CMD_MEM_RD) |=> !o_devsel_n;
endproperty
a_claim: assert property (p_claim) else $error("base 0 read not claimed");
property p_ad_drive; !o_trdy_n && rd_cmd |-> !o_ad_oe_n; endproperty
a_ad_drive: assert property (p_ad_drive) else $error("read data not driven");
c_retry: cover property (!o_stop_n && o_trdy_n && !data_reg);
c_fetch: cover property (o_path_req);
c_push: cover property (o_cmdq_wr);
endmodule // pta_target_checker
bind pta_target pta_target_checker i_pta_target_checker (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_ad(i_ad), .i_cbe_n(i_cbe_n), .i_frame_n(i_frame_n), .i_irdy_n(i_irdy_n), .i_bar0(i_bar0),
   .i_cmdq_full(i_cmdq_full), .o_trdy_n(o_trdy_n), .o_stop_n(o_stop_n), .o_devsel_n(o_devsel_n),
   .o_ctl_oe_n(o_ctl_oe_n), .o_ad_oe_n(o_ad_oe_n), .o_cmdq_wr(o_cmdq_wr), .o_path_req(o_path_req));

// ---- pta_pci_master.sv ----
// behavioural pci bus master facing the target
`timescale 1ns/1ps
module pta_pci_master (
   input wire i_clk, // pci clock
   input wire [31:0] i_ad, // resolved ad bus
   input wire i_trdy_n, // resolved trdy
   input wire i_stop_n, // resolved stop
   input wire i_devsel_n, // resolved devsel
   output reg [31:0] o_ad, // master ad drive
   output reg [3:0] o_cbe_n, // command / byte enables
   output reg o_frame_n, // frame
   output reg o_irdy_n, // initiator ready
   output reg o_idsel // config select
);
// ----------------------------------------
// idle bus at time zero
// ----------------------------------------
initial begin
   o_ad = 32'h0;
   o_cbe_n = 4'hF;
   o_frame_n = 1'b1;
   o_irdy_n = 1'b1;
   o_idsel = 1'b0;
end
// one transaction; term 0 done, 1 retry, 2 disconnect, 3 abort, 4 hung
task xfer(input [3:0] cmd, input [31:0] addr, input [3:0] be_n, input [31:0] wd,
   input burst, input sel, input integer dly, output [31:0] rd, output [2:0] term);
   integer n;
   reg got;
   reg st;
   reg ab;
   reg fin;
   begin
      got = 1'b0;
      st = 1'b0;
      ab = 1'b0;
      fin = 1'b0;
      rd = 32'h0;
      @(negedge i_clk);
      o_frame_n = 1'b0;
      o_ad = addr;
      o_cbe_n = cmd;
      o_idsel = sel;
      @(negedge i_clk);
      o_frame_n = !burst && (dly == 0);
      o_cbe_n = be_n;
      o_idsel = 1'b0;
      // reads release ad: inverse pattern so a stale value cannot pass
      o_ad = cmd[0] ? wd : ~addr;
      o_irdy_n = (dly != 0);
      for (n = 1; n < 90 && !fin; n = n + 1) begin
         @(posedge i_clk);
         if (!o_irdy_n && !i_trdy_n) begin
            got = 1'b1;
            rd = i_ad;
         end
         if (!i_stop_n) begin
            st = 1'b1;
            ab = i_devsel_n;
         end
         fin = !o_irdy_n && o_frame_n && (!i_trdy_n || !i_stop_n);
         @(negedge i_clk);
         if (fin) begin
            o_frame_n = 1'b1;
            o_irdy_n = 1'b1;
            o_ad = ~o_ad;
         end else begin
            // frame may only rise together with or after irdy
            o_irdy_n = (n < dly) && !st;
            o_frame_n = (!burst || st) && !o_irdy_n;
         end
      end
      term = !fin ? 3'h4 : ab ? 3'h3 : !st ? 3'h0 : got ? 3'h2 : 3'h1;
      @(negedge i_clk);
   end
endtask
endmodule // pta_pci_master

// ---- tb_pta_target.sv ----
// self-checking testbench for the pci target access control block
`timescale 1ns/1ps
`include "pta_consts.vh"
module tb_pta_target;
localparam [31:0] FB_VAL = 32'h6B1E_93C7;
localparam [31:0] WD = 32'hC3D2_E1F0;
localparam [31:0] B0 = 32'h1000_0000;
localparam [31:0] B1 = 32'h2000_0000;
localparam [31:0] RB = 32'h3000_0000;
reg i_clk, i_rst_n, i_busy, i_dma, i_full, ack;
reg [31:0] reg_val, fb_rd, rd, q_wd, fb_addr;
reg [35:0] q_last;
reg [3:0] fb_be;
reg [2:0] term;
integer n_mismatch, tests_run, n_push, n_regwr, n_fb, fb_cnt, n_snp;
wire [31:0] m_ad, d_ad, r_wdata, f_addr, bus_ad;
wire [3:0] m_cbe_n, f_be_n;
wire m_frame_n, m_irdy_n, m_idsel, ad_oe_n, d_trdy_n, d_stop_n, d_devsel_n, ctl_oe_n;
wire reg_wr, f_req, q_wr, snp;
wire [35:0] q_data;
// bus resolution: released control lines are pulled up
assign bus_ad = ad_oe_n ? m_ad : d_ad;
pta_pci_master i_pta_pci_master (.i_clk(i_clk), .i_ad(bus_ad), .i_trdy_n(ctl_oe_n | d_trdy_n),
   .i_stop_n(ctl_oe_n | d_stop_n), .i_devsel_n(ctl_oe_n | d_devsel_n), .o_ad(m_ad),
   .o_cbe_n(m_cbe_n), .o_frame_n(m_frame_n), .o_irdy_n(m_irdy_n), .o_idsel(m_idsel));
pta_target i_pta_target (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ad(bus_ad), .i_cbe_n(m_cbe_n),
   .i_frame_n(m_frame_n), .i_irdy_n(m_irdy_n), .i_idsel(m_idsel), .o_ad(d_ad),
   .o_ad_oe_n(ad_oe_n), .o_trdy_n(d_trdy_n), .o_stop_n(d_stop_n), .o_devsel_n(d_devsel_n),
   .o_ctl_oe_n(ctl_oe_n), .i_bar0(B0), .i_bar1(B1), .i_rom_bar(RB), .i_rom_en(1'b1),
   .i_busy(i_busy), .i_dma_active(i_dma), .o_reg_rd(), .o_reg_wr(reg_wr), .o_cfg_sel(),
   .o_reg_addr(), .o_reg_wdata(r_wdata), .i_reg_rdata(reg_val), .o_path_req(f_req),
   .o_path_addr(f_addr), .o_path_be_n(f_be_n), .i_path_ack(ack), .i_path_rdata(fb_rd),
   .i_cmdq_full(i_full), .o_cmdq_wr(q_wr), .o_cmdq_data(q_data), .o_cmdq_is_addr(),
   .o_snoop(snp));
// ----------------------------------------
// clock, access-path responder, near-side monitors
// ----------------------------------------
initial begin
   i_clk = 1'b0;
   forever #20 i_clk = ~i_clk;
end
// access path answers 16 clocks after a request
always @(negedge i_clk) begin
   ack = (fb_cnt == 1);
   fb_rd = (fb_cnt == 1) ? FB_VAL : ~FB_VAL;
   if (f_req) begin
      fb_cnt = 16;
      n_fb = n_fb + 1;
      fb_be = f_be_n;
      fb_addr = f_addr;
   end else if (fb_cnt != 0) begin
      fb_cnt = fb_cnt - 1;
   end
end
// count queue pushes and register writes
always @(posedge i_clk) begin
   if (q_wr) begin
      n_push = n_push + 1;
      q_last = q_data;
   end
   if (reg_wr) begin
      n_regwr = n_regwr + 1;
      q_wd = r_wdata;
   end
   if (snp) n_snp = n_snp + 1;
end
// ----------------------------------------
// checking helpers
// ----------------------------------------
task check(input [35:0] seen, input [35:0] exp);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
endtask
task stop_test;
   begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   end
endtask
task run(input [3:0] c, input [31:0] a, input [3:0] be, input b, input s, input integer dl);
   begin
      i_pta_pci_master.xfer(c, a, be, WD, b, s, dl, rd, term);
      if (term === 3'h4) begin
         n_mismatch = n_mismatch + 1;
         stop_test;
      end
   end
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_reads;
   begin
      run(`PTA_CMD_MEM_RD, B0 | 32'h40, 4'h0, 1'b0, 1'b0, 3);
      check({term, rd}, {3'h0, reg_val});
      i_busy = 1'b1;
      run(`PTA_CMD_MEM_RD_LINE, B0 | 32'h40, 4'h0, 1'b0, 1'b0, 0);
      check(term, 3'h1);
      run(`PTA_CMD_MEM_RD, B0 | 32'h20_0080, 4'h0, 1'b0, 1'b0, 0);
      check({term, n_fb[3:0]}, {3'h1, 4'h0});
      reg_val = 32'h0F0F_A55A;
      run(`PTA_CMD_MEM_RD, B1 | 32'h1_0008, 4'h0, 1'b0, 1'b0, 0);
      check({term, rd}, {3'h0, reg_val});
      i_busy = 1'b0;
      run(`PTA_CMD_MEM_RD_LINE, B0 | 32'h40, 4'h0, 1'b0, 1'b0, 0);
      check({term, rd}, {3'h0, reg_val});
      $display("test reads done");
   end
endtask
task t_fetch;
   begin
      run(`PTA_CMD_MEM_RD, B0 | 32'h20_0080, 4'h0, 1'b0, 1'b0, 0);
      check({term, rd, n_fb[3:0]}, {3'h0, FB_VAL, 4'h1});
      run(`PTA_CMD_MEM_RD, B1 | 32'h2_0004, 4'hE, 1'b0, 1'b0, 0);
      check({term, rd}, {3'h0, FB_VAL});
      check({fb_be, fb_addr[19:0]}, {4'h0, 20'h8_0010});
      run(`PTA_CMD_MEM_RD_MULT, B0 | 32'h40, 4'h0, 1'b1, 1'b0, 0);
      check({term, rd}, {3'h2, reg_val});
      run(`PTA_CMD_MEM_RD, B0 | 32'h10_0000, 4'h0, 1'b0, 1'b0, 0);
      check({term, rd}, {3'h0, 32'h0});
      $display("test fetch done");
   end
endtask
task t_writes;
   begin
      run(`PTA_CMD_MEM_WR_INV, B0 | 32'h40, 4'h0, 1'b0, 1'b0, 0);
      check({term, n_push[3:0], q_last}, {3'h0, 4'h2, 4'h0, WD});
      i_full = 1'b1;
      run(`PTA_CMD_MEM_WR, B0 | 32'h40, 4'h0, 1'b0, 1'b0, 0);
      check({term, n_push[3:0]}, {3'h1, 4'h2});
      i_full = 1'b0;
      run(`PTA_CMD_MEM_WR, B1 | 32'h10, 4'h3, 1'b0, 1'b0, 2);
      check({term, n_regwr[3:0], q_wd}, {3'h0, 4'h1, WD});
      run(`PTA_CMD_MEM_WR, B1 | 32'h10, `PTA_BE_NONE, 1'b0, 1'b0, 0);
      check({term, n_regwr[3:0]}, {3'h0, 4'h1});
      run(`PTA_CMD_MEM_WR, RB | 32'h100, 4'h0, 1'b0, 1'b0, 0);
      check({term, n_regwr[3:0], n_push[3:0]}, {3'h0, 4'h1, 4'h2});
      $display("test writes done");
   end
endtask
task t_io_cfg;
   begin
      run(`PTA_CMD_IO_RD, 32'h03C4, 4'hD, 1'b0, 1'b0, 0);
      check(term, 3'h3);
      run(`PTA_CMD_IO_RD, 32'h03C4, 4'hE, 1'b0, 1'b0, 0);
      check(term, 3'h0);
      run(`PTA_CMD_IO_WR, 32'h03C8, 4'hE, 1'b0, 1'b0, 0);
      check({term, n_snp[3:0], n_regwr[3:0]}, {3'h0, 4'h1, 4'h2});
      run(`PTA_CMD_CFG_RD, 32'h40, 4'h0, 1'b0, 1'b1, 0);
      check({term, rd}, {3'h0, 32'h0});
      run(`PTA_CMD_CFG_RD, 32'h0, 4'h0, 1'b1, 1'b1, 0);
      check(term, 3'h2);
      $display("test io and config done");
   end
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
   n_mismatch = 0;
   tests_run = 0;
   n_push = 0;
   n_regwr = 0;
   n_fb = 0;
   n_snp = 0;
   fb_cnt = 0;
   i_rst_n = 1'b0;
   i_busy = 1'b0;
   i_dma = 1'b0;
   i_full = 1'b0;
   reg_val = 32'h5A3C_0F96;
   repeat (2) @(negedge i_clk);
   i_rst_n = 1'b1;
   t_reads;
   t_fetch;
   t_writes;
   t_io_cfg;
   stop_test;
end
endmodule // tb_pta_target
